//--- hw/tms_map.vh
// Register offsets, field positions, reset values and timing counts of the timer sync block
`ifndef TMS_MAP_VH
`define TMS_MAP_VH

`define TMS_OFF_CTRL     12'h000
`define TMS_OFF_MODE     12'h004
`define TMS_OFF_SLAVE    12'h008
`define TMS_OFF_EVGEN    12'h00C
`define TMS_OFF_COUNT    12'h010
`define TMS_OFF_PRESC    12'h014
`define TMS_OFF_RELOAD   12'h018
`define TMS_OFF_CMP1     12'h01C
`define TMS_OFF_STATUS   12'h020
`define TMS_OFF_INTEN    12'h024
`define TMS_OFF_INTCLR   12'h028

// CTRL fields
`define TMS_CTRL_RUN     0
`define TMS_CTRL_DBGFRZ  1
// MODE: master output select
`define TMS_MOS_LSB      4
`define TMS_MOS_MSB      6
// SLAVE fields
`define TMS_SMS_LSB      0
`define TMS_SMS_MSB      2
`define TMS_TIS_LSB      4
`define TMS_TIS_MSB      6
`define TMS_MSD_BIT      7
// EVGEN: soft update generate
`define TMS_EVG_UPD      0
// STATUS / INTEN / INTCLR fields
`define TMS_ST_UPD       0
`define TMS_ST_TRG       1
`define TMS_ST_W         2

`define TMS_MOS_RESET    3'h0
`define TMS_MOS_ENABLE   3'h1
`define TMS_MOS_UPDATE   3'h2
`define TMS_MOS_CMP1     3'h4
`define TMS_SMS_OFF      3'h0
`define TMS_SMS_GATED    3'h5
`define TMS_SMS_TRIG     3'h6
`define TMS_SMS_EXTCLK   3'h7
`define TMS_TIS_INTERNAL_TRIGGER_LINE0     3'h0
`define TMS_TIS_CH1      3'h4

`define TMS_RST_RELOAD   32'h0000_FFFF
`define TMS_RST_ZERO     32'h0000_0000
// Sync stages on incoming triggers
`define TMS_SYNC_STAGES  3

`endif

//--- hw/tms_sync.v
// Master/slave timer synchronisation core with APB registers
//
// Local design decisions: register access over APB and the register addresses.
`include "tms_map.vh"

module tms_sync #(
   parameter CNT_W = 32                          // Counter width
)(
   input  wire        CORE_CLK_IN,               // Timer clock, 100 MHz
   input  wire        RST_IN,                    // Async reset, active high
   input  wire        CLK_EN_IN,                 // Freezes all state when low
   input  wire        PSEL_IN,                   // APB select
   input  wire        PENABLE_IN,                // APB enable
   input  wire        PWRITE_IN,                 // APB direction
   input  wire [11:0] PADDR_IN,                  // APB byte address
   input  wire [31:0] PWDATA_IN,                 // APB write data
   output reg  [31:0] PRDATA_OUT,                // APB read data
   output reg         PREADY_OUT,                // APB ready
   output reg         PSLVERR_OUT,               // APB error, unmapped address
   input  wire        INTERNAL_TRIGGER_LINE0_LINE_IN,              // Internal trigger line0 from another timer
   input  wire        CHAN1_INPUT_IN,            // Channel-1 input pin
   input  wire        DEBUG_HALT_IN,             // Core halted for debug
   output reg         TRIGGER_OUTPUT_OUT,        // Trigger output to slave timers
   output reg         CHAN1_CMP_REF_OUT,         // Channel-1 compare reference
   output reg         IRQ_OUT                    // Level interrupt
);

   reg  [1:0]       ctrl_reg;
   reg  [2:0]       mos_reg;
   reg  [2:0]       sms_reg;
   reg  [2:0]       tis_reg;
   reg              msd_reg;
   reg  [CNT_W-1:0] cnt_reg;
   reg  [15:0]      psc_reg;
   reg  [15:0]      pcnt_reg;
   reg  [CNT_W-1:0] arr_reg;
   reg  [CNT_W-1:0] ccr1_reg;
   reg  [1:0]       st_reg;
   reg  [1:0]       ie_reg;
   reg              run_d_reg;
   reg              trg_d_reg;
   reg              ug_reg;
   reg              dbg_reg;
   wire [1:0]       pin_raw = {CHAN1_INPUT_IN, INTERNAL_TRIGGER_LINE0_LINE_IN};
   wire [1:0]       pin_agreed;
   localparam [31:0] RST_RELOAD = `TMS_RST_RELOAD;

   wire             acc      = PSEL_IN & PENABLE_IN & ~PREADY_OUT;
   wire             wr       = acc & PWRITE_IN;
   wire             rd       = acc & ~PWRITE_IN;
   wire             dbg_frz  = ctrl_reg[`TMS_CTRL_DBGFRZ] & dbg_reg;
   wire             tick_en  = CLK_EN_IN & ~dbg_frz;
   reg              trg_sel;
   reg              mapped;
   reg  [31:0]      rdata;

   // Channel-1 and internal trigger pass three stages; a change counts once stages 2 and 3 agree.
   // This drops one-cycle glitches, so a peer must hold a trigger pulse for two clocks.
   genvar           g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : g_resync
         reg [`TMS_SYNC_STAGES-1:0] stage_reg;
         reg                        agreed_reg;
         always @(posedge CORE_CLK_IN or posedge RST_IN)
         begin
            if (RST_IN)
            begin
               stage_reg  <= {`TMS_SYNC_STAGES{1'b0}};
               agreed_reg <= 1'b0;
            end
            else if (CLK_EN_IN)
            begin
               stage_reg <= {stage_reg[`TMS_SYNC_STAGES-2:0], pin_raw[g]};
               if (stage_reg[`TMS_SYNC_STAGES-1] == stage_reg[`TMS_SYNC_STAGES-2])
                  agreed_reg <= stage_reg[`TMS_SYNC_STAGES-1];
            end
         end
         assign pin_agreed[g] = agreed_reg;
      end
   endgenerate

   // Halt level is registered once
   always @(posedge CORE_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
         dbg_reg <= 1'b0;
      else if (CLK_EN_IN)
         dbg_reg <= DEBUG_HALT_IN;
   end

   always @*
   begin
      case (tis_reg)
         `TMS_TIS_INTERNAL_TRIGGER_LINE0: trg_sel = pin_agreed[0];
         `TMS_TIS_CH1:  trg_sel = pin_agreed[1];
         default:       trg_sel = 1'b0;
      endcase
   end

   wire trg_rise  = trg_sel & ~trg_d_reg;
   wire trg_mode  = (sms_reg == `TMS_SMS_TRIG);
   wire gate_mode = (sms_reg == `TMS_SMS_GATED);
   wire ext_mode  = (sms_reg == `TMS_SMS_EXTCLK);
   wire trig_start = trg_mode & trg_rise & ~ctrl_reg[`TMS_CTRL_RUN];
   wire run_sig = ctrl_reg[`TMS_CTRL_RUN] & (~gate_mode | trg_sel);
   // delayed run path when master/slave delay set
   wire run_psc = msd_reg ? run_d_reg : run_sig;
   // trigger edge is the counting clock
   wire psc_clk = ext_mode ? trg_rise : 1'b1;
   wire psc_tick = tick_en & run_psc & psc_clk;
   wire psc_wrap = psc_tick & (pcnt_reg == psc_reg);
   wire ovf      = psc_wrap & (cnt_reg == arr_reg);

   // Write strobes, one per writable register; a write lands on the access edge
   wire             wr_ctrl   = wr & (PADDR_IN == `TMS_OFF_CTRL);
   wire             wr_mode   = wr & (PADDR_IN == `TMS_OFF_MODE);
   wire             wr_slave  = wr & (PADDR_IN == `TMS_OFF_SLAVE);
   wire             wr_evgen  = wr & (PADDR_IN == `TMS_OFF_EVGEN);
   wire             wr_count  = wr & (PADDR_IN == `TMS_OFF_COUNT);
   wire             wr_presc  = wr & (PADDR_IN == `TMS_OFF_PRESC);
   wire             wr_reload = wr & (PADDR_IN == `TMS_OFF_RELOAD);
   wire             wr_cmp1   = wr & (PADDR_IN == `TMS_OFF_CMP1);
   wire             wr_inten  = wr & (PADDR_IN == `TMS_OFF_INTEN);
   wire             wr_intclr = wr & (PADDR_IN == `TMS_OFF_INTCLR);
   wire             soft_upd  = wr_evgen & PWDATA_IN[`TMS_EVG_UPD];

   // Configuration registers
   always @(posedge CORE_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         mos_reg  <= `TMS_MOS_RESET;
         sms_reg  <= `TMS_SMS_OFF;
         tis_reg  <= `TMS_TIS_INTERNAL_TRIGGER_LINE0;
         msd_reg  <= 1'b0;
         psc_reg  <= 16'h0000;
         arr_reg  <= RST_RELOAD[CNT_W-1:0];
         ccr1_reg <= {CNT_W{1'b0}};
         ie_reg   <= 2'h0;
      end
      else if (CLK_EN_IN)
      begin
         if (wr_mode)
            mos_reg <= PWDATA_IN[`TMS_MOS_MSB:`TMS_MOS_LSB];
         if (wr_slave)
         begin
            sms_reg <= PWDATA_IN[`TMS_SMS_MSB:`TMS_SMS_LSB];
            tis_reg <= PWDATA_IN[`TMS_TIS_MSB:`TMS_TIS_LSB];
            msd_reg <= PWDATA_IN[`TMS_MSD_BIT];
         end
         if (wr_presc)
            psc_reg <= PWDATA_IN[15:0];
         if (wr_reload)
            arr_reg <= PWDATA_IN[CNT_W-1:0];
         if (wr_cmp1)
            ccr1_reg <= PWDATA_IN[CNT_W-1:0];
         if (wr_inten)
            ie_reg <= PWDATA_IN[1:0];
      end
   end

   // Control bits; a trigger start in the same cycle as a write still sets run
   always @(posedge CORE_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
         ctrl_reg <= 2'h0;
      else if (CLK_EN_IN)
      begin
         if (wr_ctrl)
            ctrl_reg <= PWDATA_IN[1:0] | {1'b0, trig_start};
         else if (trig_start)
            ctrl_reg[`TMS_CTRL_RUN] <= 1'b1;
      end
   end

   // Counter and prescaler; a software load beats a count on the same edge
   always @(posedge CORE_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         cnt_reg  <= {CNT_W{1'b0}};
         pcnt_reg <= 16'h0000;
      end
      else if (CLK_EN_IN)
      begin
         // soft update clears counter and prescaler
         if (soft_upd)
         begin
            cnt_reg  <= {CNT_W{1'b0}};
            pcnt_reg <= 16'h0000;
         end
         else
         begin
            if (psc_tick)
               pcnt_reg <= psc_wrap ? 16'h0000 : pcnt_reg + 16'h0001;
            if (wr_count)
               cnt_reg <= PWDATA_IN[CNT_W-1:0];
            else if (psc_wrap)
               cnt_reg <= (cnt_reg == arr_reg) ? {CNT_W{1'b0}} : cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // Status flags and one-cycle pipelines
   always @(posedge CORE_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         st_reg    <= 2'h0;
         run_d_reg <= 1'b0;
         trg_d_reg <= 1'b0;
         ug_reg    <= 1'b0;
      end
      else if (CLK_EN_IN)
      begin
         trg_d_reg <= trg_sel;
         run_d_reg <= run_sig;
         ug_reg    <= soft_upd;
         st_reg <= (st_reg & ~(wr_intclr ? PWDATA_IN[1:0] : 2'h0)) | {trig_start, ovf};
      end
   end

   // Outputs are registered so slaves see one clean edge per event
   always @(posedge CORE_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
         CHAN1_CMP_REF_OUT <= 1'b0;
      else if (CLK_EN_IN)
         CHAN1_CMP_REF_OUT <= (cnt_reg < ccr1_reg);
   end

   always @(posedge CORE_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
         IRQ_OUT <= 1'b0;
      else if (CLK_EN_IN)
         IRQ_OUT <= |(st_reg & ie_reg);
   end

   // Soft update leaves one cycle late, since it passes through ug_reg
   always @(posedge CORE_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
         TRIGGER_OUTPUT_OUT <= 1'b0;
      else if (CLK_EN_IN)
      begin
         case (mos_reg)
            `TMS_MOS_RESET:  TRIGGER_OUTPUT_OUT <= ug_reg;
            `TMS_MOS_ENABLE: TRIGGER_OUTPUT_OUT <= run_sig;
            `TMS_MOS_UPDATE: TRIGGER_OUTPUT_OUT <= ovf;
            `TMS_MOS_CMP1:   TRIGGER_OUTPUT_OUT <= (cnt_reg < ccr1_reg);
            default:         TRIGGER_OUTPUT_OUT <= 1'b0;
         endcase
      end
   end

   always @*
   begin
      mapped = 1'b1;
      rdata  = 32'h0000_0000;
      case (PADDR_IN)
         `TMS_OFF_CTRL:   rdata[1:0] = ctrl_reg;
         `TMS_OFF_MODE:   rdata[`TMS_MOS_MSB:`TMS_MOS_LSB] = mos_reg;
         `TMS_OFF_SLAVE:  rdata[7:0] = {msd_reg, tis_reg, 1'b0, sms_reg};
         `TMS_OFF_EVGEN:  rdata = 32'h0000_0000;
         `TMS_OFF_COUNT:  rdata[CNT_W-1:0] = cnt_reg;
         `TMS_OFF_PRESC:  rdata[15:0] = psc_reg;
         `TMS_OFF_RELOAD: rdata[CNT_W-1:0] = arr_reg;
         `TMS_OFF_CMP1:   rdata[CNT_W-1:0] = ccr1_reg;
         `TMS_OFF_STATUS: rdata[1:0] = st_reg;
         `TMS_OFF_INTEN:  rdata[1:0] = ie_reg;
         `TMS_OFF_INTCLR: rdata = 32'h0000_0000;
         default:         mapped = 1'b0;
      endcase
   end

   // One wait state: ready rises the cycle after penable, then drops
   always @(posedge CORE_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         PREADY_OUT  <= 1'b0;
         PSLVERR_OUT <= 1'b0;
      end
      else if (CLK_EN_IN)
      begin
         PREADY_OUT  <= acc;
         PSLVERR_OUT <= acc & ~mapped;
      end
   end

   // Read data holds until the next read
   always @(posedge CORE_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
         PRDATA_OUT <= 32'h0000_0000;
      else if (CLK_EN_IN & rd)
         PRDATA_OUT <= rdata;
   end

endmodule // tms_sync

//--- sim/tms_peer_mdl.sv
// Model of a master timer that drives the internal trigger line
module tms_peer_mdl (
   input  wire logic clk_in,    // Timer clock
   input  wire logic rst_in,    // Async reset
   input  wire logic go_in,     // Master counter running
   input  wire logic pulse_in,  // Update mode, else enable mode
   output logic      trig_out,  // Trigger output
   output int        pulses_out // Update pulses sent
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] div_reg;
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         div_reg <= 2'h0;
         trig_out <= 1'b0;
         pulses_out <= 0;
      end
      else
      begin
         div_reg <= go_in ? div_reg + 2'h1 : 2'h0;
         // pulse or level
         // Two-clock pulse so the slave's resync filter keeps it
         trig_out <= pulse_in ? (go_in && div_reg[1]) : go_in;
         if (pulse_in && go_in && div_reg == 2'h3)
            pulses_out <= pulses_out + 1;
      end
   end
endmodule // tms_peer_mdl

//--- sim/tms_sync_props.sv
// Checker of the timer sync block ports
`include "tms_map.vh"
module tms_sync_props (
   input wire logic        CORE_CLK_IN,        // Clock
   input wire logic        RST_IN,             // Reset
   input wire logic        CLK_EN_IN,          // Clock enable
   input wire logic        PSEL_IN,            // APB select
   input wire logic        PENABLE_IN,         // APB enable
   input wire logic        PWRITE_IN,          // APB direction
   input wire logic [11:0] PADDR_IN,           // APB address
   input wire logic [31:0] PWDATA_IN,          // APB write data
   input wire logic        PREADY_OUT,         // APB ready
   input wire logic        PSLVERR_OUT,        // APB error
   input wire logic        INTERNAL_TRIGGER_LINE0_LINE_IN,       // Trigger line0
   input wire logic        CHAN1_INPUT_IN,     // Channel-1 pin
   input wire logic        TRIGGER_OUTPUT_OUT, // Trigger output
   input wire logic        CHAN1_CMP_REF_OUT,  // Compare reference
   input wire logic        IRQ_OUT             // Interrupt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] mos_reg, sms_reg, tis_reg;
   wire wr_go = CLK_EN_IN && PSEL_IN && PENABLE_IN && PWRITE_IN && !PREADY_OUT;
   wire trg_sel = (tis_reg == `TMS_TIS_CH1) ? CHAN1_INPUT_IN : INTERNAL_TRIGGER_LINE0_LINE_IN;
   // Shadow of the mode fields, so the trigger relations know what is selected
   always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
         {mos_reg, sms_reg, tis_reg} <= 9'h000;
      else if (wr_go && PADDR_IN == `TMS_OFF_MODE)
         mos_reg <= PWDATA_IN[6:4];
      else if (wr_go && PADDR_IN == `TMS_OFF_SLAVE)
         {tis_reg, sms_reg} <= {PWDATA_IN[6:4], PWDATA_IN[2:0]};
   end
   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (RST_IN);
   ready_wait_a: assert property (CLK_EN_IN && PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT) // APB
      else $error("ready late");
   ready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT) // APB
      else $error("ready too long");
   err_ready_a: assert property (PSLVERR_OUT |-> PREADY_OUT) // APB
      else $error("error without ready");
   ready_cause_a: assert property (PREADY_OUT |-> $past(PENABLE_IN) && $past(PSEL_IN)) // APB
      else $error("ready without access");
   cmp_route_a: assert property ((mos_reg == `TMS_MOS_CMP1 && $stable(CHAN1_CMP_REF_OUT)) [*3]
      |-> TRIGGER_OUTPUT_OUT == CHAN1_CMP_REF_OUT) else $error("trigger not compare reference");
   upd_pulse_a: assert property (mos_reg == `TMS_MOS_UPDATE && TRIGGER_OUTPUT_OUT
      |=> !TRIGGER_OUTPUT_OUT) else $error("update pulse too long");
   trig_start_a: assert property (sms_reg == `TMS_SMS_TRIG && mos_reg == `TMS_MOS_ENABLE
      && !TRIGGER_OUTPUT_OUT && $rose(trg_sel) |-> !TRIGGER_OUTPUT_OUT [*4] ##[1:4] TRIGGER_OUTPUT_OUT)
      else $error("trigger start latency");
   reset_quiet_a: assert property ($fell(RST_IN) |-> !IRQ_OUT && !TRIGGER_OUTPUT_OUT) // RESET
      else $error("outputs active after reset");
endmodule // tms_sync_props

bind tms_sync tms_sync_props i_props (.CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN), .CLK_EN_IN(CLK_EN_IN),
   .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
   .PWDATA_IN(PWDATA_IN), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .INTERNAL_TRIGGER_LINE0_LINE_IN(INTERNAL_TRIGGER_LINE0_LINE_IN),
   .CHAN1_INPUT_IN(CHAN1_INPUT_IN), .TRIGGER_OUTPUT_OUT(TRIGGER_OUTPUT_OUT),
   .CHAN1_CMP_REF_OUT(CHAN1_CMP_REF_OUT), .IRQ_OUT(IRQ_OUT));

//--- sim/tms_sync_tb.sv
// Self-checking bench of the timer sync block
`include "tms_map.vh"
module tms_sync_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, ch1 = 0, halt = 0, go = 0, pls = 0;
   logic [11:0] pa = 12'h000;
   logic [31:0] pwd = 32'h0000_0000, rdat, prd, c1;
   logic        prdy, perr, errs, trg, cref, irq, itr;
   int          miscompares = 0, checks_done = 0, pulses;
   logic [43:0] rows [5] = '{{`TMS_OFF_CTRL, 32'h0000_0000}, {`TMS_OFF_SLAVE, 32'h0000_0000},
      {`TMS_OFF_COUNT, 32'h0000_0000}, {`TMS_OFF_RELOAD, `TMS_RST_RELOAD}, {`TMS_OFF_STATUS, 32'h0000_0000}};
   always #5 clk = ~clk;
   tms_sync i_tms_sync (.CORE_CLK_IN(clk), .RST_IN(rst), .CLK_EN_IN(1'b1), .PSEL_IN(psel), .PENABLE_IN(pen),
      .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(prdy), .PSLVERR_OUT(perr),
      .INTERNAL_TRIGGER_LINE0_LINE_IN(itr), .CHAN1_INPUT_IN(ch1), .DEBUG_HALT_IN(halt), .TRIGGER_OUTPUT_OUT(trg),
      .CHAN1_CMP_REF_OUT(cref), .IRQ_OUT(irq));
   tms_peer_mdl i_peer (.clk_in(clk), .rst_in(rst), .go_in(go), .pulse_in(pls), .trig_out(itr),
      .pulses_out(pulses));
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checks_done++;
      if (s !== e)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Request held until the edge that samples ready; a stuck slave ends the run
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      {psel, pwr, pa, pwd} <= {1'b1, w, a, d};
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (prdy !== 1'b1 && n < 20);
      rdat = prd;
      errs = perr;
      @(posedge clk);
      {psel, pen} <= 2'b00;
      if (n >= 20)
      begin
         miscompares++;
         tally_and_finish();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, e, rdat);
   endtask
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i])
         rd("reset value", rows[i][43:32], rows[i][31:0]); // RESET
      rd("unmapped data", 12'h0FC, 32'h0000_0000); // APB
      chk("unmapped error", 1, errs); // APB
      wr(`TMS_OFF_SLAVE, 32'h0000_0005);
      wr(`TMS_OFF_COUNT, 32'h0000_00E7);
      wr(`TMS_OFF_CTRL, 32'h0000_0001);
      repeat (10) @(posedge clk);
      rd("gated hold", `TMS_OFF_COUNT, 32'h0000_00E7);
      go <= 1'b1;
      repeat (30) @(posedge clk);
      go <= 1'b0;
      repeat (10) @(posedge clk);
      apb(1'b0, `TMS_OFF_COUNT, 32'h0000_0000);
      c1 = rdat;
      chk("gated advance", 1, c1 >= 32'h0000_0103 && c1 <= 32'h0000_0107);
      repeat (10) @(posedge clk);
      rd("gated stop", `TMS_OFF_COUNT, c1);
      wr(`TMS_OFF_EVGEN, 32'h0000_0001);
      rd("soft update", `TMS_OFF_COUNT, 32'h0000_0000);
      wr(`TMS_OFF_SLAVE, 32'h0000_0007);
      {pls, go} <= 2'b11;
      repeat (40) @(posedge clk);
      go <= 1'b0;
      repeat (10) @(posedge clk);
      rd("external clock", `TMS_OFF_COUNT, pulses);
      wr(`TMS_OFF_CTRL, 32'h0000_0000);
      wr(`TMS_OFF_MODE, 32'h0000_0010);
      wr(`TMS_OFF_INTCLR, 32'h0000_0003);
      wr(`TMS_OFF_INTEN, 32'h0000_0002);
      wr(`TMS_OFF_SLAVE, 32'h0000_0046);
      {ch1, pls} <= 2'b10;
      repeat (10) @(posedge clk);
      chk("run on trigger output", 1, trg);
      chk("trigger interrupt", 1, irq);
      rd("run set by trigger", `TMS_OFF_CTRL, 32'h0000_0001);
      rd("trigger flag", `TMS_OFF_STATUS, 32'h0000_0002);
      wr(`TMS_OFF_INTCLR, 32'h0000_0002);
      wr(`TMS_OFF_CTRL, 32'h0000_0000);
      repeat (3) @(posedge clk);
      chk("interrupt cleared", 0, irq);
      chk("run cleared", 0, trg);
      wr(`TMS_OFF_SLAVE, 32'h0000_0000);
      wr(`TMS_OFF_RELOAD, 32'h0000_0009);
      wr(`TMS_OFF_CMP1, 32'h0000_0004);
      wr(`TMS_OFF_EVGEN, 32'h0000_0001);
      wr(`TMS_OFF_MODE, 32'h0000_0020);
      wr(`TMS_OFF_CTRL, 32'h0000_0001);
      c1 = 0;
      repeat (40)
      begin
         @(negedge clk);
         c1 += trg;
      end
      chk("update pulses", 4, c1);
      wr(`TMS_OFF_MODE, 32'h0000_0040);
      repeat (40)
      begin
         @(negedge clk);
         chk("compare on trigger", cref, trg);
      end
      wr(`TMS_OFF_CTRL, 32'h0000_0003);
      halt <= 1'b1;
      apb(1'b0, `TMS_OFF_COUNT, 32'h0000_0000);
      c1 = rdat;
      repeat (5) @(posedge clk);
      rd("debug freeze", `TMS_OFF_COUNT, c1);
      wr(`TMS_OFF_CTRL, 32'h0000_0000);
      wr(`TMS_OFF_SLAVE, 32'h0000_0080);
      wr(`TMS_OFF_EVGEN, 32'h0000_0001);
      wr(`TMS_OFF_CTRL, 32'h0000_0001);
      rd("delayed start", `TMS_OFF_COUNT, 32'h0000_0002);
      tally_and_finish();
   end
endmodule // tms_sync_tb
